// ### dv/mbs_sequencer_monitor.sv
`timescale 1ns/10ps
module mbs_sequencer_monitor (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic        pready,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        full_barrier_instr,
  input logic        write_barrier_instr,
  input logic        barrier_cmd,
  input logic        barrier_done_response,
  input logic        mark_probe,
  input logic        marked_probe_resp_sent,
  input logic        barrier_complete,
  input logic        map_stall,
  input logic        merge_close,
  input logic        miss_stall,
  input logic        store_queue_empty,
  input logic        load_queue_empty,
  input logic        dxlate_move_queued,
  input logic        issue_sb_bit4,
  input logic        issue_sb_bit0,
  input logic        barrier_ack
);
  logic sys_q;
  logic fill_q;
  logic resp_q;
  // mirror of control bits and of the marked probe answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_q  <= 1'h0;
      fill_q <= 1'h1;
      resp_q <= 1'h0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == 12'h000) begin
        sys_q  <= pwdata[0];
        fill_q <= pwdata[1];
      end
      if (marked_probe_resp_sent)
        resp_q <= 1'h1;
      else if (barrier_complete)
        resp_q <= 1'h0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_apb; psel && !penable |=> pready; endproperty
  a_apb: assert property (p_apb) else $error("no ready after setup");
  property p_map; full_barrier_instr |=> map_stall; endproperty
  a_map: assert property (p_map) else $error("map not held");
  property p_merge; write_barrier_instr && !map_stall |-> ##[1:4] merge_close; endproperty
  a_merge: assert property (p_merge) else $error("merge not closed");
  property p_mstall; merge_close |-> miss_stall; endproperty
  a_mstall: assert property (p_mstall) else $error("processing not stalled");
  property p_cmd; barrier_cmd |-> sys_q; endproperty
  a_cmd: assert property (p_cmd) else $error("command in counting mode");
  property p_mark; barrier_done_response |=> mark_probe; endproperty
  a_mark: assert property (p_mark) else $error("no mark after done");
  property p_ack; barrier_done_response |=> barrier_ack; endproperty
  a_ack: assert property (p_ack) else $error("no internal acknowledge");
  property p_cmpl; barrier_complete |-> resp_q; endproperty
  a_cmpl: assert property (p_cmpl) else $error("complete before probe answer");
  property p_drain;
    barrier_complete && $past(map_stall) |-> $past(store_queue_empty && load_queue_empty);
  endproperty
  a_drain: assert property (p_drain) else $error("complete before drain");
  property p_sb; dxlate_move_queued |=> issue_sb_bit4 && issue_sb_bit0; endproperty
  a_sb: assert property (p_sb) else $error("scoreboard not set");
  property p_sb0;
    $fell(issue_sb_bit0) |-> barrier_complete || $past(barrier_complete) || !fill_q;
  endproperty
  a_sb0: assert property (p_sb0) else $error("bit0 cleared early");
endmodule

// ### dv/mbs_sys_model.sv
`timescale 1ns/10ps
module mbs_sys_model (
  input  logic       pclk,
  input  logic       presetn,
  input  logic       barrier_cmd,
  input  logic       mark_probe,
  input  logic       cmd_issued,
  input  logic       hold,
  input  logic [3:0] dly,
  output logic       barrier_done_response,
  output logic       marked_probe_resp_sent,
  output logic       system_data_control_cmd_commit
);
  logic [4:0] pend;
  logic [4:0] t;
  logic [1:0] m;
  logic       c;
  assign c = !hold && pend != 5'h00 && !system_data_control_cmd_commit;
  // system side: commits, barrier answers, probe answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 5'h00;
      t    <= 5'h00;
      m    <= 2'h0;
      system_data_control_cmd_commit <= 1'h0;
      barrier_done_response  <= 1'h0;
      marked_probe_resp_sent <= 1'h0;
    end else begin
      pend <= pend + {4'h0, cmd_issued} - {4'h0, c};
      system_data_control_cmd_commit <= c;
      t <= barrier_cmd ? {1'h0, dly} + 5'h01 : (t != 5'h00 ? t - 5'h01 : 5'h00);
      barrier_done_response <= t == 5'h01;
      m <= mark_probe ? 2'h2 : (m != 2'h0 ? m - 2'h1 : 2'h0);
      marked_probe_resp_sent <= m == 2'h1;
    end
  end
endmodule

// ### dv/mbs_testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        full, wb, cmd, pc, qe, drn, dq, di, xq, xi, xl, hold;
  logic        map_stall, miss_stall, barrier_cmd, mark_probe, barrier_complete;
  logic        issue_sb_bit0, fetch_stall, bdr, mprs, sdc, fp, pr;
  logic [3:0]  dly;
  logic [16:0] rs;
  logic [64:0] q[$];
  integer      errors, checks, cyc, m, k;
  mbs_sequencer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .full_barrier_instr(full), .integer_issue_queue_empty(qe),
    .write_barrier_instr(wb), .cmd_issued(cmd), .probe_commit(pc), .system_data_control_cmd_commit(sdc),
    .miss_address_file_empty(drn), .miss_address_file_dstream_empty(drn),
    .io_write_buffer_empty(drn), .store_queue_empty(drn), .load_queue_empty(drn),
    .barrier_done_response(bdr), .marked_probe_resp_sent(mprs), .probe_queue_empty(drn),
    .dxlate_move_queued(dq), .dxlate_move_issued(di), .ixlate_move_queued(xq),
    .ixlate_move_issued(xi), .ixlate_load_done(xl), .map_stall, .flush_pending(fp),
    .miss_stall, .merge_close(), .barrier_cmd, .barrier_ack(), .mark_probe,
    .barrier_complete, .issue_sb_bit4(), .issue_sb_bit0, .fetch_stall, .prefetch_restart(pr));
  mbs_sys_model u_sys (.pclk, .presetn, .barrier_cmd, .mark_probe, .cmd_issued(cmd), .hold,
    .dly, .barrier_done_response(bdr), .marked_probe_resp_sent(mprs), .system_data_control_cmd_commit(sdc));
  function logic [16:0] lf(input logic [16:0] s);
    lf = {s[15:0], s[16] ^ s[13]};
  endfunction
  task chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task conclude;
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [64:0] e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask
  task pulse_ev(input integer k);
    integer i;
    rs = lf(rs);
    dly <= rs[3:0];
    {hold, qe, drn} <= 3'h4;
    @(posedge pclk) cmd <= 1;
    @(posedge pclk) {cmd, full, wb, dq, xq, xl} <= {1'h0, k == 0, k == 1, k == 2, {2{k == 3}}};
    @(posedge pclk) {full, wb, dq, xq, xl, di, xi} <= {5'h00, k == 2, k == 3};
    @(posedge pclk) {di, xi} <= 2'h0;
    repeat (3) @(posedge pclk);
    chk(k == 0, map_stall);
    chk(k == 3, fetch_stall);
    chk(k >= 2, issue_sb_bit0);
    chk(k >= 2, fp);
    {hold, qe, drn} <= 3'h3;
    i = 0;
    @(posedge pclk);
    while (barrier_complete !== 1'h1 && i < 300) begin
      @(posedge pclk);
      i++;
    end
    chk(1, i < 300);
    chk(k == 3, pr);
    repeat (3) @(posedge pclk);
    chk(0, map_stall | issue_sb_bit0);
  endtask
  // read results against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      chk(q[0][31:0], prdata & q[0][63:32]);
      chk(q[0][64], pslverr);
      void'(q.pop_front());
    end
  end
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      conclude;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, full, wb, cmd, pc, dq, di, xq, xi, xl, hold} = 0;
    {qe, drn} = 2'h3;
    {paddr, pwdata, dly} = 0;
    {errors, checks, cyc} = 0;
    rs = 17'd70691;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0, {1'h0, 32'hFFFFFFFF, 32'h00000002});
    apb(0, 12'h008, 0, {1'h1, 32'hFFFFFFFF, 32'h00000000});
    hold <= 1;
    repeat (17) begin
      @(posedge pclk) cmd <= 1;
      @(posedge pclk) cmd <= 0;
    end
    apb(0, 12'h004, 0, {1'h0, 32'h0000000F, 32'h0000000F});
    chk(1, miss_stall);
    hold <= 0;
    repeat (60) @(posedge pclk);
    @(posedge pclk) pc <= 1;
    @(posedge pclk) pc <= 0;
    apb(0, 12'h004, 0, {1'h0, 32'h0000000F, 32'h00000000});
    chk(0, miss_stall);
    for (m = 0; m < 2; m++) begin
      apb(1, 12'h000, {30'h0, 1'h1, m[0]}, 0);
      for (k = 0; k < 4; k++) pulse_ev(k);
    end
    apb(1, 12'h000, 0, 0);
    @(posedge pclk) dq <= 1;
    @(posedge pclk) {dq, di} <= 2'h1;
    @(posedge pclk) di <= 0;
    repeat (3) @(posedge pclk);
    chk(0, issue_sb_bit0 | map_stall);
    conclude;
  end
endmodule
bind mbs_sequencer mbs_sequencer_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .paddr, .pwdata, .full_barrier_instr, .write_barrier_instr, .barrier_cmd,
  .barrier_done_response, .mark_probe, .marked_probe_resp_sent, .barrier_complete, .map_stall,
  .merge_close, .miss_stall, .store_queue_empty, .load_queue_empty, .dxlate_move_queued,
  .issue_sb_bit4, .issue_sb_bit0, .barrier_ack);

// ### rtl/mbs_regs.vh
`ifndef MBS_REGS_VH
`define MBS_REGS_VH
// register byte offsets
`define MBS_CTRL_OFF     12'h000
`define MBS_STATUS_OFF   12'h004
// control fields
`define MBS_CTRL_SYSEN   0
`define MBS_CTRL_FILLEN  1
`define MBS_CTRL_RST     2'h2
// status fields
`define MBS_ST_CNT_LO    0
`define MBS_ST_STATE_LO  4
`define MBS_ST_KIND_LO   8
`define MBS_ST_STALL     12
`define MBS_ST_FSTALL    13
// counter limits
`define MBS_CNT_MAX      4'hF
`define MBS_CNT_ZERO     4'h0
// barrier kinds
`define MBS_K_FULL       2'h0
`define MBS_K_WRITE      2'h1
`define MBS_K_DXL        2'h2
`define MBS_K_IXL        2'h3
`endif

// ### rtl/mbs_sequencer.v
// What this block does
// - enable bit picks external command or counting
// - 4-bit counter counts issued system commands
// - each commit flag decrements the counter
// - saturate at 15, stall miss and write
// - probes serviced whatever the counter holds
// - full barrier holds map until barrier completes
// - counting mode flushes, marks when counter falls to zero or is zero
// - resume after drains and marked probe response
// - command mode flushes, sends, waits, then marks
// - write barrier arrives after stores writable
// - write barrier closes merge, stalls processing
// - counting write barrier done after marked response
// - command write barrier acked by done response
// - data fill move sets scoreboard 4 and 0
// - data move issue starts barrier, bit 0 held
// - fill barrier completion clears scoreboard bit 0
// - instruction fill barrier, fetch stall, prefetch
// - fill barriers only with fill enable set
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "mbs_regs.vh"
module mbs_sequencer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        full_barrier_instr,
  input  wire        integer_issue_queue_empty,
  input  wire        write_barrier_instr,
  input  wire        cmd_issued,
  input  wire        probe_commit,
  input  wire        system_data_control_cmd_commit,
  input  wire        miss_address_file_empty,
  input  wire        miss_address_file_dstream_empty,
  input  wire        io_write_buffer_empty,
  input  wire        store_queue_empty,
  input  wire        load_queue_empty,
  input  wire        barrier_done_response,
  input  wire        marked_probe_resp_sent,
  input  wire        probe_queue_empty,
  input  wire        dxlate_move_queued,
  input  wire        dxlate_move_issued,
  input  wire        ixlate_move_queued,
  input  wire        ixlate_move_issued,
  input  wire        ixlate_load_done,
  output reg         map_stall,
  output reg         flush_pending,
  output reg         miss_stall,
  output reg         merge_close,
  output reg         barrier_cmd,
  output reg         barrier_ack,
  output reg         mark_probe,
  output reg         barrier_complete,
  output reg         issue_sb_bit4,
  output reg         issue_sb_bit0,
  output reg         fetch_stall,
  output reg         prefetch_restart
);

  // sequencer state codes
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WIQ   = 3'h1;
  localparam [2:0] ST_FLUSH = 3'h2;
  localparam [2:0] ST_SEND  = 3'h3;
  localparam [2:0] ST_WACK  = 3'h4;
  localparam [2:0] ST_WZERO = 3'h5;
  localparam [2:0] ST_WFIN  = 3'h6;

  // control bits, counter, state and pending requests
  reg [1:0] ctrl_reg;
  reg [3:0] cnt_reg;
  reg [3:0] cnt_next;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] kind_reg;
  reg [1:0] kind_next;
  reg       mode_reg;
  reg       full_pend_reg;
  reg       wmb_pend_reg;
  reg       dxl_pend_reg;
  reg       ixl_pend_reg;
  reg       marked_reg;
  reg       resp_reg;
  // one-cycle strobes from the next-state logic
  reg       start;
  reg       fin;
  reg       mark_now;
  // decoded control and drain terms
  wire      sys_en;
  wire      fill_en;
  wire      fall_zero;
  wire      drained;
  wire      wr_acc;
  wire      rd_setup;

  // saturating counter step, one up and up to two down
  function [3:0] cnt_step;
    input [3:0] cur;
    input       up;
    input       dn_a;
    input       dn_b;
    reg   [4:0] t;
    begin
      t = {1'b0, cur};
      // increment held at the ceiling
      if (up && cur != `MBS_CNT_MAX)
        t = t + 5'h01;
      if (dn_a && t != 5'h00)
        t = t - 5'h01;
      if (dn_b && t != 5'h00)
        t = t - 5'h01;
      cnt_step = t[3:0];
    end
  endfunction

  // control bits and apb qualifiers
  assign sys_en   = ctrl_reg[`MBS_CTRL_SYSEN];
  assign fill_en  = ctrl_reg[`MBS_CTRL_FILLEN];
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;

  // apb slave, one wait-free access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `MBS_CTRL_RST;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h00000000;
    end else begin
      pready  <= rd_setup;
      // unmapped offsets answer with an error and read as zero
      pslverr <= rd_setup & (paddr != `MBS_CTRL_OFF) &
                 (paddr != `MBS_STATUS_OFF);
      prdata  <= 32'h00000000;
      if (rd_setup && !pwrite && paddr == `MBS_CTRL_OFF)
        prdata <= {30'h00000000, ctrl_reg};
      if (rd_setup && !pwrite && paddr == `MBS_STATUS_OFF) begin
        prdata[`MBS_ST_CNT_LO +: 4]   <= cnt_reg;
        prdata[`MBS_ST_STATE_LO +: 3] <= state_reg;
        prdata[`MBS_ST_KIND_LO +: 2]  <= kind_reg;
        prdata[`MBS_ST_STALL]         <= miss_stall;
        prdata[`MBS_ST_FSTALL]        <= fetch_stall;
      end
      // write lands in the access phase
      if (wr_acc && pready && paddr == `MBS_CTRL_OFF)
        ctrl_reg <= pwdata[1:0];
    end
  end

  // counter next value
  always @* begin
    // count issued commands in counting mode
    // commit flags from probe and data control
    cnt_next = cnt_step(cnt_reg, cmd_issued & ~sys_en,
                        probe_commit, system_data_control_cmd_commit);
  end

  // nonzero-to-zero transition of the counter, by one or two steps
  // fall to zero marks probe entry
  assign fall_zero = (cnt_reg != `MBS_CNT_ZERO) && (cnt_next == `MBS_CNT_ZERO);

  // drain conditions before resuming
  // miss file, queues and write buffer empty
  assign drained = miss_address_file_dstream_empty & store_queue_empty &
                   load_queue_empty & io_write_buffer_empty;

  // barrier sequencer next state
  always @* begin
    state_next = state_reg;
    kind_next  = kind_reg;
    start      = 1'b0;
    fin        = 1'b0;
    mark_now   = 1'b0;
    case (state_reg)
      // priority: write, data fill, instr fill, full
      ST_IDLE: begin
        if (wmb_pend_reg) begin
          kind_next  = `MBS_K_WRITE;
          start      = 1'b1;
          state_next = sys_en ? ST_SEND : ST_WZERO;
        end else if (dxl_pend_reg) begin
          kind_next  = `MBS_K_DXL;
          start      = 1'b1;
          state_next = ST_FLUSH;
        end else if (ixl_pend_reg) begin
          kind_next  = `MBS_K_IXL;
          start      = 1'b1;
          state_next = ST_FLUSH;
        end else if (full_pend_reg) begin
          kind_next  = `MBS_K_FULL;
          start      = 1'b1;
          state_next = ST_WIQ;
        end
      end
      // work starts once issue queue empty
      ST_WIQ: begin
        if (integer_issue_queue_empty)
          state_next = ST_FLUSH;
      end
      // flush pending entries to the port
      ST_FLUSH: begin
        if (miss_address_file_empty && io_write_buffer_empty)
          state_next = mode_reg ? ST_SEND : ST_WZERO;
      end
      // one barrier command on the port
      ST_SEND: begin
        state_next = ST_WACK;
      end
      ST_WACK: begin
        if (barrier_done_response) begin
          mark_now   = 1'b1;
          state_next = ST_WFIN;
        end
      end
      // marked entry on fall to zero
      ST_WZERO: begin
        // zero already means nothing uncommitted
        if (fall_zero || cnt_reg == `MBS_CNT_ZERO) begin
          mark_now   = 1'b1;
          state_next = ST_WFIN;
        end
      end
      ST_WFIN: begin
        // write barrier needs no drains
        if ((resp_reg || marked_probe_resp_sent) &&
            (kind_reg == `MBS_K_WRITE || drained)) begin
          fin        = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer registers and pending requests
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= ST_IDLE;
      kind_reg      <= `MBS_K_FULL;
      mode_reg      <= 1'b0;
      cnt_reg       <= `MBS_CNT_ZERO;
      full_pend_reg <= 1'b0;
      wmb_pend_reg  <= 1'b0;
      dxl_pend_reg  <= 1'b0;
      ixl_pend_reg  <= 1'b0;
      marked_reg    <= 1'b0;
      resp_reg      <= 1'b0;
    end else begin
      // state, kind and counter advance
      state_reg <= state_next;
      kind_reg  <= kind_next;
      cnt_reg   <= cnt_next;
      if (start)
        mode_reg <= sys_en;
      if (full_barrier_instr)
        full_pend_reg <= 1'b1;
      else if (start && kind_next == `MBS_K_FULL)
        full_pend_reg <= 1'b0;
      if (write_barrier_instr)
        wmb_pend_reg <= 1'b1;
      else if (start && kind_next == `MBS_K_WRITE)
        wmb_pend_reg <= 1'b0;
      if (dxlate_move_issued && fill_en)
        dxl_pend_reg <= 1'b1;
      else if (start && kind_next == `MBS_K_DXL)
        dxl_pend_reg <= 1'b0;
      if (ixlate_move_issued && fill_en)
        ixl_pend_reg <= 1'b1;
      else if (start && kind_next == `MBS_K_IXL)
        ixl_pend_reg <= 1'b0;
      // marked entry forgotten at completion, so a late
      // probe answer cannot satisfy the next barrier
      if (start || fin)
        marked_reg <= 1'b0;
      else if (mark_now)
        marked_reg <= 1'b1;
      // response for the marked entry, set wins
      if (marked_reg && marked_probe_resp_sent)
        resp_reg <= 1'b1;
      else if (start)
        resp_reg <= 1'b0;
    end
  end

  // registered control outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_stall        <= 1'b0;
      flush_pending    <= 1'b0;
      miss_stall       <= 1'b0;
      merge_close      <= 1'b0;
      barrier_cmd      <= 1'b0;
      barrier_ack      <= 1'b0;
      mark_probe       <= 1'b0;
      barrier_complete <= 1'b0;
      prefetch_restart <= 1'b0;
    end else begin
      map_stall <= (full_pend_reg | full_barrier_instr) |
                   (state_next != ST_IDLE && kind_next == `MBS_K_FULL);
      flush_pending <= (state_next == ST_FLUSH);
      // write barrier stalls in both modes
      miss_stall <= (cnt_next == `MBS_CNT_MAX) ||
                    (state_next != ST_IDLE && kind_next == `MBS_K_WRITE);
      merge_close <= start && kind_next == `MBS_K_WRITE;
      barrier_cmd <= (state_reg == ST_SEND);
      barrier_ack <= mark_now && state_reg == ST_WACK;
      mark_probe       <= mark_now;
      // completion strobes
      barrier_complete <= fin;
      prefetch_restart <= fin && kind_reg == `MBS_K_IXL;
    end
  end

  // issue scoreboard and fetch stall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      issue_sb_bit4 <= 1'b0;
      issue_sb_bit0 <= 1'b0;
      fetch_stall   <= 1'b0;
    end else begin
      // queued fill move sets bits 4 and 0
      if (dxlate_move_queued || ixlate_move_queued)
        issue_sb_bit4 <= 1'b1;
      else if (dxlate_move_issued || ixlate_move_issued)
        issue_sb_bit4 <= 1'b0;
      // bit 0 stays set while barrier runs
      // cleared on completion of injected barrier
      // without fill enable cleared at issue
      if (dxlate_move_queued || ixlate_move_queued)
        issue_sb_bit0 <= 1'b1;
      else if (fin && (kind_reg == `MBS_K_DXL || kind_reg == `MBS_K_IXL))
        issue_sb_bit0 <= 1'b0;
      else if ((dxlate_move_issued || ixlate_move_issued) && !fill_en)
        issue_sb_bit0 <= 1'b0;
      // fetch stalled until probe queue drains
      if (ixlate_load_done && fill_en)
        fetch_stall <= 1'b1;
      else if (probe_queue_empty)
        fetch_stall <= 1'b0;
    end
  end

endmodule
